/* rtl/ecp_bus_if.sv */
// Parallel processor bus between master and echo canceller port
`timescale 1ns/1ps
`default_nettype none
interface ecp_bus_if;
  import ecp_pkg::*;

  logic [7:0] host_ad;
  logic host_ad_oe;
  logic [7:0] dev_ad;
  logic dev_ad_oe;
  logic [7:0] ad;
  logic [6:0] addr;
  logic ale;
  logic cs_n;
  logic rds_n;
  logic wrw;
  logic rdy;

  // Shared address/data wire with pull-up
  assign ad = dev_ad_oe ? dev_ad : (host_ad_oe ? host_ad : BUS_IDLE);

  modport dev (
    input ad, addr, ale, cs_n, rds_n, wrw,
    output dev_ad, dev_ad_oe, rdy
  );

  modport host (
    input ad, rdy,
    output host_ad, host_ad_oe, addr, ale, cs_n, rds_n, wrw
  );
endinterface
`default_nettype wire

/* rtl/ecp_dev.sv */
// Device end of the parallel processor port with register file
`timescale 1ns/1ps
`default_nettype none
module ecp_dev
  import ecp_pkg::*;
#(
  parameter int NC = NCOEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  ecp_bus_if.dev bus,
  input wire logic mode_ds_in,
  input wire logic addr_mux_in,
  input wire logic [AW-1:0] core_addr_in,
  output logic [DW-1:0] core_data_out,
  input wire logic coef_we_in,
  input wire logic [CIW-1:0] coef_idx_in,
  input wire logic [DW-1:0] coef_data_in,
  output logic unlocked_out
);

  typedef struct packed {
    ecp_dst_t st;
    logic rd;
    logic [3:0] ctl1;
    logic [3:0] ctl2;
    logic ale_q;
    logic [7:0] ad1;
    logic [7:0] ad2;
    logic [6:0] ab1;
    logic [6:0] ab2;
    logic [6:0] lat;
    logic [7:0] rdat;
    logic unl;
    logic [7:0] core;
  } ecp_dev_st_t;

  ecp_dev_st_t q_ff;
  ecp_dev_st_t nxt_q;

  logic [DW-1:0] regs_ff [NREG];
  logic [DW-1:0] coef_ff [NC];

  logic ale_s;
  logic cs_n_s;
  logic sa_s;
  logic sb_s;
  logic [AW-1:0] acc_addr;
  logic rd_act;
  logic wr_act;
  logic reg_we;
  logic [DW-1:0] wdat;
  logic [DW-1:0] rd_val;
  logic is_wp;
  logic is_coef;
  logic is_prot;
  logic wr_ok;
  logic [CIW-1:0] coef_sel;

  // ----------------------------------------------------------------
  // Strobe decode
  // ----------------------------------------------------------------
  // Reads only the second synchroniser stage
  always_comb begin
    ale_s = q_ff.ctl2[3];
    cs_n_s = q_ff.ctl2[2];
    sa_s = q_ff.ctl2[1];
    sb_s = q_ff.ctl2[0];
    wdat = q_ff.ad2;
    if (mode_ds_in) begin
      rd_act = !(cs_n_s | sa_s) && sb_s;
      wr_act = !(cs_n_s | sa_s) && !sb_s;
    end else begin
      // Both strobes low: read wins
      rd_act = !(cs_n_s | sa_s);
      wr_act = !(cs_n_s | sb_s) && sa_s;
    end
  end

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  always_comb begin
    acc_addr = addr_mux_in ? q_ff.lat : q_ff.ab2;
    is_wp = (acc_addr == WP_ADDR);
    is_coef = (acc_addr >= COEF_BASE) && (acc_addr <= COEF_LAST);
    is_prot = (acc_addr >= PROT_BASE) && !is_wp;
    coef_sel = CIW'(acc_addr - COEF_BASE);
    // Coefficients are read only; protected words need the unlock
    if (is_prot) begin
      wr_ok = q_ff.unl;
    end else begin
      wr_ok = !is_coef && !is_wp;
    end
    if (is_wp) begin
      rd_val = {WP_PAD, q_ff.unl};
    end else if (is_coef) begin
      rd_val = coef_ff[coef_sel];
    end else begin
      rd_val = regs_ff[acc_addr];
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    reg_we = 1'b0;
    // Two-flop synchronisers on every pin
    nxt_q.ctl1 = {bus.ale, bus.cs_n, bus.rds_n, bus.wrw};
    nxt_q.ctl2 = q_ff.ctl1;
    nxt_q.ad1 = bus.ad;
    nxt_q.ad2 = q_ff.ad1;
    nxt_q.ab1 = bus.addr;
    nxt_q.ab2 = q_ff.ab1;
    nxt_q.ale_q = ale_s;
    nxt_q.core = regs_ff[core_addr_in];
    // Address taken where the synced latch enable falls
    if (q_ff.ale_q && !ale_s) begin
      nxt_q.lat = q_ff.ad2[AW-1:0];
    end
    // Answer once per access, then wait for its release
    unique case (q_ff.st)
      DS_IDLE: begin
        if (rd_act) begin
          nxt_q.rdat = rd_val;
          nxt_q.rd = 1'b1;
          nxt_q.st = DS_ACK;
        end else if (wr_act) begin
          nxt_q.rd = 1'b0;
          nxt_q.st = DS_ACK;
          reg_we = wr_ok;
          if (is_wp) begin
            nxt_q.unl = (wdat == UNLOCK_CODE);
          end
        end
      end
      // Ready stands until strobe or select is released
      DS_ACK: begin
        if (!(rd_act || wr_act)) begin
          nxt_q.st = DS_IDLE;
        end
      end
    endcase
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_ff <= '0;
      // Synced pins start idle: select and strobes high
      q_ff.ctl1 <= PIN_IDLE;
      q_ff.ctl2 <= PIN_IDLE;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // One word per register, written only at its own address
  for (genvar gi = 0; gi < NREG; gi++) begin : g_reg
    always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
        regs_ff[gi] <= REG_RST;
      end else if (reg_we && (acc_addr == AW'(gi))) begin
        regs_ff[gi] <= wdat;
      end
    end
  end

  // Coefficient mirror written by the filter core, no reset
  for (genvar gc = 0; gc < NC; gc++) begin : g_coef
    always_ff @(posedge clk_in) begin
      if (coef_we_in && (coef_idx_in == CIW'(gc))) begin
        coef_ff[gc] <= coef_data_in;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Shared bus is driven only while a read is answered
  assign bus.dev_ad = q_ff.rdat;
  assign bus.dev_ad_oe = (q_ff.st == DS_ACK) && q_ff.rd;
  assign bus.rdy = (q_ff.st == DS_ACK);
  assign core_data_out = q_ff.core;
  assign unlocked_out = q_ff.unl;

endmodule
`default_nettype wire

/* rtl/ecp_host.sv */
// Master end that runs read and write cycles on the processor port
`timescale 1ns/1ps
`default_nettype none
module ecp_host
  import ecp_pkg::*;
(
  input wire logic clk_in,
  input wire logic rst_in,
  ecp_bus_if.host bus,
  input wire logic mode_ds_in,
  input wire logic addr_mux_in,
  input wire logic req_in,
  input wire logic we_in,
  input wire logic [AW-1:0] addr_in,
  input wire logic [DW-1:0] wdata_in,
  output logic ready_out,
  output logic done_out,
  output logic [DW-1:0] rdata_out
);

  typedef struct packed {
    ecp_hst_t st;
    logic [3:0] cnt;
    logic r1;
    logic r2;
    logic [7:0] ad1;
    logic [7:0] ad2;
    logic we;
    logic [6:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic done;
    logic [7:0] ad_o;
    logic ad_oe;
    logic ale;
    logic cs_n;
    logic sa;
    logic sb;
  } ecp_host_st_t;

  ecp_host_st_t q_ff;
  ecp_host_st_t nxt_q;

  // ----------------------------------------------------------------
  // Cycle sequencer
  // ----------------------------------------------------------------
  always_comb begin
    nxt_q = q_ff;
    nxt_q.r1 = bus.rdy;
    nxt_q.r2 = q_ff.r1;
    nxt_q.ad1 = bus.ad;
    nxt_q.ad2 = q_ff.ad1;
    nxt_q.done = 1'b0;
    nxt_q.cnt = q_ff.cnt + CNT_ONE;
    unique case (q_ff.st)
      HS_IDLE: begin
        nxt_q.cnt = CNT_ZERO;
        if (req_in) begin
          nxt_q.we = we_in;
          nxt_q.addr = addr_in;
          nxt_q.wdata = wdata_in;
          if (addr_mux_in) begin
            nxt_q.ad_o = {1'b0, addr_in};
            nxt_q.ad_oe = 1'b1;
            nxt_q.ale = 1'b1;
            nxt_q.st = HS_ALE;
          end else begin
            nxt_q.ad_o = wdata_in;
            nxt_q.ad_oe = we_in;
            nxt_q.sb = mode_ds_in ? !we_in : 1'b1;
            nxt_q.st = HS_SET;
          end
        end
      end
      HS_ALE: begin
        if (q_ff.cnt == ALE_CYC - CNT_ONE) begin
          nxt_q.ale = 1'b0;
          nxt_q.cnt = CNT_ZERO;
          nxt_q.st = HS_ADR;
        end
      end
      HS_ADR: begin
        if (q_ff.cnt == ALE_CYC - CNT_ONE) begin
          nxt_q.ad_o = q_ff.wdata;
          nxt_q.ad_oe = q_ff.we;
          nxt_q.sb = mode_ds_in ? !q_ff.we : 1'b1;
          nxt_q.cnt = CNT_ZERO;
          nxt_q.st = HS_SET;
        end
      end
      HS_SET: begin
        if (q_ff.cnt == SETUP_CYC - CNT_ONE) begin
          nxt_q.cs_n = 1'b0;
          nxt_q.sa = mode_ds_in ? 1'b0 : q_ff.we;
          nxt_q.sb = !q_ff.we;
          nxt_q.st = HS_STB;
        end
      end
      HS_STB: begin
        if (q_ff.r2) begin
          if (!q_ff.we) begin
            nxt_q.rdata = q_ff.ad2;
          end
          nxt_q.cs_n = 1'b1;
          nxt_q.sa = 1'b1;
          nxt_q.sb = 1'b1;
          nxt_q.ad_oe = 1'b0;
          nxt_q.st = HS_REL;
        end
      end
      HS_REL: begin
        if (!q_ff.r2) begin
          nxt_q.done = 1'b1;
          nxt_q.st = HS_IDLE;
        end
      end
      default: begin
        nxt_q.st = HS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      q_ff <= '0;
      q_ff.cs_n <= 1'b1;
      q_ff.sa <= 1'b1;
      q_ff.sb <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.host_ad = q_ff.ad_o;
  assign bus.host_ad_oe = q_ff.ad_oe;
  assign bus.addr = q_ff.addr;
  assign bus.ale = q_ff.ale;
  assign bus.cs_n = q_ff.cs_n;
  assign bus.rds_n = q_ff.sa;
  assign bus.wrw = q_ff.sb;
  assign ready_out = (q_ff.st == HS_IDLE);
  assign done_out = q_ff.done;
  assign rdata_out = q_ff.rdata;

endmodule
`default_nettype wire

/* rtl/ecp_pkg.sv */
// Shared constants and types for the echo canceller host port
package ecp_pkg;

  localparam int AW = 7;
  localparam int DW = 8;
  localparam int NREG = 128;
  localparam int NCOEF = 32;
  localparam int CIW = 5;

  // Address map
  localparam logic [6:0] COEF_BASE = 7'h40;
  localparam logic [6:0] COEF_LAST = 7'h5F;
  localparam logic [6:0] PROT_BASE = 7'h60;
  localparam logic [6:0] WP_ADDR = 7'h7F;

  // Values
  localparam logic [7:0] UNLOCK_CODE = 8'h95;
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [7:0] BUS_IDLE = 8'hFF;
  localparam logic [6:0] WP_PAD = 7'h00;
  localparam logic [3:0] PIN_IDLE = 4'h7;

  // Master timing, in clk_in cycles
  localparam logic [3:0] ALE_CYC = 4'h3;
  localparam logic [3:0] SETUP_CYC = 4'h3;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [3:0] CNT_ZERO = 4'h0;

  typedef enum logic [0:0] {
    DS_IDLE = 1'b0,
    DS_ACK = 1'b1
  } ecp_dst_t;

  typedef enum logic [2:0] {
    HS_IDLE = 3'b000,
    HS_ALE = 3'b001,
    HS_ADR = 3'b010,
    HS_SET = 3'b011,
    HS_STB = 3'b100,
    HS_REL = 3'b101
  } ecp_hst_t;

endpackage

/* verif/echo_canceller_host_port_tb.sv */
// Self-checking bench for both ends of the processor port
`timescale 1ns/1ps
`default_nettype none
module echo_canceller_host_port_tb import ecp_pkg::*;;
  logic clk_in = 1'b0, rst_in = 1'b1, mode_ds = 1'b0, addr_mux = 1'b0, req = 1'b0, we = 1'b0;
  logic coef_we = 1'b0, unl = 1'b0, ready, done, unlocked;
  logic [6:0] addr = 7'h00, core_addr = 7'h00, a;
  logic [7:0] wdata = 8'h00, coef_data = 8'h00, rdata, core_data;
  logic [4:0] coef_idx = 5'h00;
  logic [7:0] mdl [NREG] = '{default: 8'h00};
  logic [15:0] seed = 16'hE1E1;
  int failures, num_checks, cycles;
  ecp_bus_if bus ();
  ecp_dev i_ecp_dev (.clk_in(clk_in), .rst_in(rst_in), .bus(bus), .mode_ds_in(mode_ds),
    .addr_mux_in(addr_mux), .core_addr_in(core_addr), .core_data_out(core_data), .coef_we_in(coef_we),
    .coef_idx_in(coef_idx), .coef_data_in(coef_data), .unlocked_out(unlocked));
  ecp_host i_ecp_host (.clk_in(clk_in), .rst_in(rst_in), .bus(bus), .mode_ds_in(mode_ds),
    .addr_mux_in(addr_mux), .req_in(req), .we_in(we), .addr_in(addr), .wdata_in(wdata),
    .ready_out(ready), .done_out(done), .rdata_out(rdata));
  ecp_checker i_ecp_checker (.clk_in(clk_in), .rst_in(rst_in), .ad(bus.ad), .dev_ad(bus.dev_ad),
    .dev_ad_oe(bus.dev_ad_oe), .host_ad_oe(bus.host_ad_oe), .rdy(bus.rdy), .cs_n(bus.cs_n), .rds_n(bus.rds_n),
    .wrw(bus.wrw), .ale(bus.ale));
  always #2 clk_in = ~clk_in;
  // ----------
  // Expectations
  // ----------
  function automatic logic [15:0] lfsr(input logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  function automatic logic [7:0] rd_exp(input logic [6:0] ra);
    return (ra == WP_ADDR) ? {WP_PAD, unl} : mdl[ra];
  endfunction
  function automatic void mdl_wr(input logic [6:0] wa, input logic [7:0] d);
    if (wa == WP_ADDR)
      unl = (d == UNLOCK_CODE);
    else if (wa < COEF_BASE || (wa >= PROT_BASE && unl))
      mdl[wa] = d;
  endfunction
  task automatic check(input string nm, input logic [7:0] got, input logic [7:0] want);
    num_checks++;
    if (got !== want) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, want, got);
    end
  endtask
  task automatic finish_test();
    if (failures == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // One transfer through the master, then compare
  task automatic op(input logic w, input logic [6:0] oa, input logic [7:0] d);
    @(negedge clk_in);
    while (ready !== 1'b1)
      @(negedge clk_in);
    @(posedge clk_in);
    seed = lfsr(seed);
    req <= 1'b1;
    we <= w;
    addr <= oa;
    wdata <= d;
    core_addr <= {1'b0, seed[5:0]};
    @(posedge clk_in);
    req <= 1'b0;
    @(negedge clk_in);
    check("ready_busy", {7'h00, ready}, 8'h00);
    while (done !== 1'b1)
      @(negedge clk_in);
    check("ready_done", {7'h00, ready}, 8'h01);
    if (w)
      mdl_wr(oa, d);
    else
      check("rdata", rdata, rd_exp(oa));
    check("unlocked", {7'h00, unlocked}, {7'h00, unl});
    check("core_data", core_data, mdl[core_addr]);
    check("bus_idle", bus.ad, BUS_IDLE);
  endtask
  always @(posedge clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
  // ----------
  // Main sequence
  // ----------
  initial begin
    repeat (6) @(posedge clk_in);
    rst_in <= 1'b0;
    for (int i = 0; i < NCOEF; i++) begin
      @(posedge clk_in);
      seed = lfsr(seed);
      coef_we <= 1'b1;
      coef_idx <= i[4:0];
      coef_data <= seed[7:0];
      mdl[COEF_BASE + i[6:0]] = seed[7:0];
    end
    @(posedge clk_in);
    coef_we <= 1'b0;
    for (int m = 0; m < 4; m++) begin
      @(posedge clk_in);
      mode_ds <= m[0];
      addr_mux <= m[1];
      for (int i = 0; i < 6; i++) begin
        seed = lfsr(seed);
        a = (i == 0) ? 7'h3F : {1'b0, seed[13:8]};
        op(1'b1, a, seed[7:0]);
        op(1'b0, a, 8'h00);
      end
      op(1'b1, 7'h7E, 8'h5A);
      op(1'b0, 7'h7E, 8'h00);
      op(1'b1, WP_ADDR, UNLOCK_CODE);
      op(1'b0, WP_ADDR, 8'h00);
      op(1'b1, PROT_BASE, seed[15:8]);
      op(1'b1, 7'h7E, 8'hA5);
      op(1'b0, 7'h7E, 8'h00);
      op(1'b1, WP_ADDR, 8'h94);
      op(1'b1, PROT_BASE, 8'hC3);
      op(1'b0, PROT_BASE, 8'h00);
      op(1'b1, COEF_LAST, 8'h11);
      op(1'b0, COEF_LAST, 8'h00);
    end
    for (int i = 0; i < NCOEF; i++)
      op(1'b0, COEF_BASE + i[6:0], 8'h00);
    finish_test();
  end
endmodule
`default_nettype wire

/* verif/ecp_checker.sv */
// Assertions on the processor port wires
`timescale 1ns/1ps
`default_nettype none
module ecp_checker (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [7:0] ad,
  input wire logic [7:0] dev_ad,
  input wire logic host_ad_oe,
  input wire logic dev_ad_oe,
  input wire logic rdy,
  input wire logic cs_n,
  input wire logic rds_n,
  input wire logic wrw,
  input wire logic ale
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // ----------
  // Access steps
  // ----------
  sequence s_start;
    $fell(cs_n) && (!rds_n || !wrw);
  endsequence
  sequence s_ack;
    !rdy ##[1:4] rdy;
  endsequence
  sequence s_drop;
    rdy ##[1:4] !rdy;
  endsequence
  a_ack_given: assert property (s_start |-> s_ack)
    else $error("no ready after strobe");
  a_ack_release: assert property ($rose(cs_n) |-> s_drop)
    else $error("ready not released");
  a_ack_needs_sel: assert property ($rose(rdy) |-> !cs_n && !$past(cs_n, 2))
    else $error("ready without select");
  a_ack_holds: assert property (rdy && !cs_n |=> rdy)
    else $error("ready dropped early");
  a_idle_quiet: assert property (cs_n [*5] |-> !rdy && !dev_ad_oe)
    else $error("activity without select");
  a_dir_drive: assert property ($rose(rdy) |-> dev_ad_oe == wrw)
    else $error("drive does not match direction");
  a_read_stable: assert property (dev_ad_oe && $past(dev_ad_oe) |-> $stable(dev_ad) && ad == dev_ad)
    else $error("read data moved");
  a_ale_before: assert property ($fell(cs_n) |-> !ale && !$past(ale))
    else $error("latch enable overlaps strobe");
  a_bus_contention: assert property (!(dev_ad_oe && host_ad_oe))
    else $error("both ends drive the bus");
endmodule
`default_nettype wire
